// ==== core/bank67_memory_timing_config.sv ====
// bank 6/7 control registers and access sequencer for static and page dram
// assumes: axi4-lite master, one access at a time on req port
//
// Functional notes
// - bits 16:15 pick static, fast-page, edo or sdram; reset to sdram.
// - static type uses low fifteen bits as static timing fields.
// - fast-page or edo type uses low six bits as dram timing fields.
// - address leads chip select by 0, 1, 2 or 4 clocks; the code gives 1, 2, 3 or 5.
// - chip select leads output enable by 0, 1, 2 or 4 clocks; the code gives 1, 2, 3 or 5.
// - access strobe lasts 1,2,3,4,6,8,10 or 14 clocks; resets to 1.
// - chip select stays 0, 1, 2 or 4 clocks after output enable; the code gives 1, 2, 3 or 5.
// - address stays 0, 1, 2 or 4 clocks after chip select drops; the code gives 1, 2, 3 or 5.
// - later page accesses last 2, 3, 4 or 6 clocks.
// - bits 1:0 pick single access or page bursts of 4, 8, 16.
// - row to column strobe delay is 1, 2, 3 or 4 clocks.
// - column strobe low 1 clock, or 2 when bit 3 set.
// - column strobe precharge 1 clock, or 2 when bit 2 set.
// - column address width 8, 9, 10 or 11 bits from bits 1:0.
// - every timing count is in bus clocks.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module bank67_memory_timing_config (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [31:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [31:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire bank67_pkg::mem_req_t      req,
  input  wire logic                      req_valid,
  input  wire logic                      req_bank7,
  output logic                           req_ready,
  output logic                           acc_done,
  output logic                           acc_error,
  output logic [31:0]                    mem_addr,
  output logic                           mem_addr_valid,
  output logic                           bank_chip_select_n,
  output logic                           output_enable_n,
  output logic                           write_enable_n,
  output logic                           ras_n,
  output logic                           cas_n,
  output logic                           col_phase,
  output logic [3:0]                     col_bits
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [4:0] dly4(input logic [1:0] c);
    case (c)
      2'b00:   dly4 = 5'd0;
      2'b01:   dly4 = 5'd1;
      2'b10:   dly4 = 5'd2;
      default: dly4 = 5'd4;
    endcase
  endfunction : dly4

  function automatic logic [4:0] acc_cycles(input logic [2:0] c);
    case (c)
      3'd0:    acc_cycles = 5'd1;
      3'd1:    acc_cycles = 5'd2;
      3'd2:    acc_cycles = 5'd3;
      3'd3:    acc_cycles = 5'd4;
      3'd4:    acc_cycles = 5'd6;
      3'd5:    acc_cycles = 5'd8;
      3'd6:    acc_cycles = 5'd10;
      default: acc_cycles = 5'd14;
    endcase
  endfunction : acc_cycles

  function automatic logic [4:0] page_cycles(input logic [1:0] c);
    case (c)
      2'b00:   page_cycles = 5'd2;
      2'b01:   page_cycles = 5'd3;
      2'b10:   page_cycles = 5'd4;
      default: page_cycles = 5'd6;
    endcase
  endfunction : page_cycles

  function automatic logic [4:0] burst_len(input logic [1:0] c);
    case (c)
      2'b00:   burst_len = 5'd1;
      2'b01:   burst_len = 5'd4;
      2'b10:   burst_len = 5'd8;
      default: burst_len = 5'd16;
    endcase
  endfunction : burst_len

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite register slave

  logic [16:0] bank6_control_r;
  logic [16:0] bank7_control_r;
  logic        aw_held_r;
  logic [31:0] aw_addr_r;
  logic        w_held_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_go;
  logic        wr_hit6;
  logic        wr_hit7;

  assign wr_go   = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_hit6 = (aw_addr_r[31:2] == bank67_pkg::bank6_control_offset[31:2]);
  assign wr_hit7 = (aw_addr_r[31:2] == bank67_pkg::bank7_control_offset[31:2]);

  function automatic logic [16:0] merge(input logic [16:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] v;
    v = {15'h0000, old};
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        v[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = v[16:0] & bank67_pkg::bank_control_mask;
  endfunction : merge

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r     <= 1'b1;
      aw_addr_r     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_held_r     <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r     <= 1'b1;
      w_data_r     <= s_axi_wdata;
      w_strb_r     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_held_r     <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank6_control_r <= bank67_pkg::bank_control_reset[16:0];
      bank7_control_r <= bank67_pkg::bank_control_reset[16:0];
    end else if (wr_go) begin
      if (wr_hit6) begin
        bank6_control_r <= merge(bank6_control_r, w_data_r, w_strb_r);
      end
      if (wr_hit7) begin
        bank7_control_r <= merge(bank7_control_r, w_data_r, w_strb_r);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bank67_pkg::axi_resp_okay;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_hit6 || wr_hit7) ? bank67_pkg::axi_resp_okay
                                           : bank67_pkg::axi_resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= bank67_pkg::axi_resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      if (s_axi_araddr[31:2] == bank67_pkg::bank6_control_offset[31:2]) begin
        s_axi_rdata <= {15'h0000, bank6_control_r};
        s_axi_rresp <= bank67_pkg::axi_resp_okay;
      end else if (s_axi_araddr[31:2] == bank67_pkg::bank7_control_offset[31:2]) begin
        s_axi_rdata <= {15'h0000, bank7_control_r};
        s_axi_rresp <= bank67_pkg::axi_resp_okay;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= bank67_pkg::axi_resp_slverr;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access sequencer

  typedef enum logic [3:0] {
    st_idle, st_setup, st_cs, st_strobe, st_page, st_hold, st_addr_hold,
    st_ras, st_cas, st_pre
  } seq_state_t;

  seq_state_t   state_r;
  logic [16:0]  cfg_r;
  logic [31:0]  addr_r;
  logic [4:0]   beats_r;
  logic         tload;
  logic [4:0]   tcount;
  logic         tbusy;
  logic [16:0]  cfg_sel;

  assign cfg_sel   = req_bank7 ? bank7_control_r : bank6_control_r;

  bank67_timer #(.W(5)) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (tload),
    .count   (tcount),
    .busy    (tbusy),
    .done    ()
  );

  // timer loads on each state entry; tbusy drops when count ran out
  logic [4:0] tcount_nxt;
  seq_state_t state_nxt;

  always_comb begin
    state_nxt  = state_r;
    tcount_nxt = 5'd0;
    case (state_r)
      st_idle: begin
        if (req_valid && req_ready) begin
          case (bank67_pkg::mem_type_t'(cfg_sel[bank67_pkg::mt_lsb +: 2]))
            bank67_pkg::mem_static: begin
              state_nxt  = st_setup;
              tcount_nxt = dly4(cfg_sel[bank67_pkg::tacs_lsb +: 2]);
            end
            bank67_pkg::mem_fp, bank67_pkg::mem_edo: begin
              state_nxt  = st_ras;
              tcount_nxt = 5'(cfg_sel[bank67_pkg::trcd_lsb +: 2]);
            end
            default: state_nxt = st_idle;
          endcase
        end
      end
      st_setup: if (!tbusy) begin
        state_nxt  = st_cs;
        tcount_nxt = dly4(cfg_r[bank67_pkg::tcos_lsb +: 2]);
      end
      st_cs: if (!tbusy) begin
        state_nxt  = st_strobe;
        tcount_nxt = acc_cycles(cfg_r[bank67_pkg::tacc_lsb +: 3]) - 5'd1;
      end
      st_strobe, st_page: if (!tbusy) begin
        if (beats_r > 5'd1) begin
          state_nxt  = st_page;
          tcount_nxt = page_cycles(cfg_r[bank67_pkg::tpac_lsb +: 2]) - 5'd1;
        end else begin
          state_nxt  = st_hold;
          tcount_nxt = dly4(cfg_r[bank67_pkg::toch_lsb +: 2]);
        end
      end
      st_hold: if (!tbusy) begin
        state_nxt  = st_addr_hold;
        tcount_nxt = dly4(cfg_r[bank67_pkg::tcah_lsb +: 2]);
      end
      st_addr_hold: if (!tbusy) state_nxt = st_idle;
      st_ras: if (!tbusy) begin
        state_nxt  = st_cas;
        tcount_nxt = cfg_r[bank67_pkg::tcas_bit] ? 5'd1 : 5'd0;
      end
      st_cas: if (!tbusy) begin
        state_nxt  = st_pre;
        tcount_nxt = cfg_r[bank67_pkg::tcp_bit] ? 5'd1 : 5'd0;
      end
      st_pre: if (!tbusy) state_nxt = st_idle;
      default: state_nxt = st_idle;
    endcase
  end

  assign tload  = (state_nxt != state_r) || (state_r == st_page && state_nxt == st_page
                  && !tbusy);
  assign tcount = tcount_nxt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  // configuration latched at access start only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r   <= bank67_pkg::bank_control_reset[16:0];
      addr_r  <= 32'h0000_0000;
      beats_r <= 5'd0;
    end else if (state_r == st_idle && req_valid && req_ready) begin
      cfg_r   <= cfg_sel;
      addr_r  <= req.addr;
      beats_r <= burst_len(cfg_sel[bank67_pkg::pmc_lsb +: 2]);
    end else if ((state_r == st_strobe || state_r == st_page) && !tbusy
                 && beats_r > 5'd1) begin
      beats_r <= beats_r - 5'd1;
      addr_r  <= addr_r + 32'h0000_0004;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered pins

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_ready          <= 1'b0;
      acc_done           <= 1'b0;
      acc_error          <= 1'b0;
      mem_addr           <= 32'h0000_0000;
      mem_addr_valid     <= 1'b0;
      bank_chip_select_n <= 1'b1;
      output_enable_n    <= 1'b1;
      write_enable_n     <= 1'b1;
      ras_n              <= 1'b1;
      cas_n              <= 1'b1;
      col_phase          <= 1'b0;
      col_bits           <= 4'd8;
    end else begin
      req_ready      <= (state_nxt == st_idle) && !(req_valid && req_ready);
      acc_done       <= (state_r != st_idle) && (state_nxt == st_idle);
      acc_error      <= (state_r == st_idle) && req_valid && req_ready
                        && (cfg_sel[bank67_pkg::mt_lsb +: 2] == bank67_pkg::mem_sdram);
      mem_addr       <= (state_nxt == st_idle) ? mem_addr
                        : ((state_r == st_idle) ? req.addr : addr_r);
      mem_addr_valid <= (state_nxt != st_idle);
      bank_chip_select_n <= !(state_nxt inside {st_cs, st_strobe, st_page, st_hold,
                                               st_ras, st_cas, st_pre});
      output_enable_n    <= !((state_nxt inside {st_strobe, st_page}) && !cfg_r_wr(state_r));
      write_enable_n     <= !((state_nxt inside {st_strobe, st_page}) && cfg_r_wr(state_r));
      ras_n              <= !(state_nxt inside {st_ras, st_cas});
      cas_n              <= !(state_nxt == st_cas);
      col_phase          <= (state_nxt == st_cas);
      col_bits           <= 4'd8 + {2'b00, cfg_r[bank67_pkg::can_lsb +: 2]};
    end
  end

  logic wr_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_r <= 1'b0;
    end else if (state_r == st_idle && req_valid && req_ready) begin
      wr_r <= req.write;
    end
  end

  function automatic logic cfg_r_wr(input seq_state_t s);
    cfg_r_wr = (s == st_idle) ? req.write : wr_r;
  endfunction : cfg_r_wr

endmodule : bank67_memory_timing_config

// ==== core/bank67_pkg.sv ====
// package: register map, field layout, reset values and types for the bank 6/7 block
// assumes: 32-bit axi4-lite register bus, all counts in bus clocks
package bank67_pkg;

  localparam logic [31:0] bank6_control_offset = 32'h01c8_001c;
  localparam logic [31:0] bank7_control_offset = 32'h01c8_0020;
  localparam logic [31:0] bank_control_reset   = 32'h0001_8008;
  localparam logic [16:0] bank_control_mask    = 17'h1_ffff;

  localparam int mt_lsb     = 15;
  localparam int tacs_lsb   = 13;
  localparam int tcos_lsb   = 11;
  localparam int tacc_lsb   = 8;
  localparam int toch_lsb   = 6;
  localparam int tcah_lsb   = 4;
  localparam int tpac_lsb   = 2;
  localparam int pmc_lsb    = 0;
  localparam int trcd_lsb   = 4;
  localparam int tcas_bit   = 3;
  localparam int tcp_bit    = 2;
  localparam int can_lsb    = 0;

  localparam logic [1:0] axi_resp_okay   = 2'h0;
  localparam logic [1:0] axi_resp_slverr = 2'h2;

  typedef enum logic [1:0] {
    mem_static = 2'b00,
    mem_fp     = 2'b01,
    mem_edo    = 2'b10,
    mem_sdram  = 2'b11
  } mem_type_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        last;
  } mem_req_t;

  typedef struct packed {
    logic [3:0] ras_cas;
    logic [1:0] cas_low;
    logic [1:0] cas_pre;
    logic [3:0] col_bits;
  } dram_timing_t;

endpackage : bank67_pkg

// ==== core/bank67_timer.sv ====
// one down counter: loads a cycle count, pulses done when it expires
// assumes: single clock, synchronous active-low reset
`timescale 1ns/1ps
module bank67_timer #(
  parameter int W = 5
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      done  <= 1'b0;
    end else if (load) begin
      cnt_r <= count;
      done  <= (count == '0);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
      done  <= (cnt_r == W'(1));
    end else begin
      done  <= 1'b0;
    end
  end

  assign busy = (cnt_r != '0);

endmodule : bank67_timer

// ==== dv/bank67_mem_model.sv ====
// model: memory on bank 6/7, measures each strobe phase of one access
// assumes: clr high for one edge before each access
`timescale 1ns/1ps
module bank67_mem_model (
  input wire logic        aclk,
  input wire logic        clr,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_addr_valid,
  input wire logic        bank_chip_select_n,
  input wire logic        output_enable_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic [3:0]  col_bits,
  output int              setup_c,
  output int              cos_c,
  output int              acc_c,
  output int              och_c,
  output int              cah_c,
  output int              beats_c,
  output int              rcd_c,
  output int              casw_c,
  output int              pre_c,
  output int              act_c,
  output logic [3:0]      col_c
);
  logic        cs_seen, oe_seen, cas_seen;
  logic [31:0] last_a;
  always @(posedge aclk) begin
    if (clr) begin
      {setup_c, cos_c, acc_c, och_c, cah_c, beats_c, rcd_c, casw_c, pre_c, act_c} = '0;
      {cs_seen, oe_seen, cas_seen} = '0;
      last_a = '1;
    end else if (mem_addr_valid) begin
      if (!bank_chip_select_n || !ras_n) act_c++;
      if (bank_chip_select_n && !cs_seen) setup_c++;
      if (bank_chip_select_n && cs_seen) cah_c++;
      if (!bank_chip_select_n && output_enable_n && !oe_seen) cos_c++;
      if (!bank_chip_select_n && output_enable_n && oe_seen) och_c++;
      if (!output_enable_n) acc_c++;
      if (!bank_chip_select_n && mem_addr !== last_a) beats_c++;
      if (!ras_n && cas_n && !cas_seen) rcd_c++;
      if (!cas_n) casw_c++;
      if (cas_seen && cas_n) pre_c++;
      if (!ras_n) col_c = col_bits;
      if (!bank_chip_select_n) cs_seen = 1'b1;
      if (!bank_chip_select_n) last_a = mem_addr;
      if (!output_enable_n) oe_seen = 1'b1;
      if (!cas_n) cas_seen = 1'b1;
    end
  end
endmodule : bank67_mem_model

// ==== dv/bank67_memory_timing_config_checker.sv ====
// checker: strobe and bus relations of the bank 6/7 block
// assumes: bound to the top module, one clock domain
`timescale 1ns/1ps
module bank67_memory_timing_config_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        acc_done,
  input wire logic        acc_error,
  input wire logic        mem_addr_valid,
  input wire logic        bank_chip_select_n,
  input wire logic        output_enable_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic [3:0]  col_bits
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  sequence cas_release;
    ##[1:2] cas_n;
  endsequence
  sequence access_end;
    ##[1:300] (acc_done || acc_error);
  endsequence
  ////////////////////////////////////////
  chk_idle_quiet: assert property (
    !mem_addr_valid |-> bank_chip_select_n && output_enable_n && ras_n && cas_n)
    else $error("strobe active while idle");
  chk_oe_in_cs: assert property (
    !output_enable_n |-> !bank_chip_select_n)
    else $error("output enable without chip select");
  chk_cas_in_ras: assert property (
    !cas_n |-> !ras_n)
    else $error("column strobe without row strobe");
  chk_cas_width: assert property (
    $fell(cas_n) |-> cas_release)
    else $error("column strobe too long");
  chk_col_range: assert property (
    !ras_n |-> col_bits inside {[4'h8:4'hb]})
    else $error("column width out of range");
  chk_error_quiet: assert property (
    acc_error |-> bank_chip_select_n && ras_n)
    else $error("strobe on refused access");
  chk_access_end: assert property (
    $rose(mem_addr_valid) |-> access_end)
    else $error("access never finished");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : bank67_memory_timing_config_checker

// ==== dv/bank67_memory_timing_config_tb.sv ====
// testbench: register map and access timing of the bank 6/7 block
// assumes: checker bound below, memory model watching the strobes
`timescale 1ns/1ps
module bank67_memory_timing_config_tb;
  localparam logic [31:0] b6 = bank67_pkg::bank6_control_offset;
  localparam logic [31:0] b7 = bank67_pkg::bank7_control_offset;
  localparam logic [31:0] rst = bank67_pkg::bank_control_reset;
  localparam logic [1:0]  ok = bank67_pkg::axi_resp_okay;
  localparam logic [1:0]  bad = bank67_pkg::axi_resp_slverr;
  typedef struct {logic wr; logic [31:0] a, d, exp; logic [1:0] rsp;} row_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, req_valid, req_bank7, req_ready, acc_done, acc_error, clr, err;
  logic        mem_addr_valid, bank_chip_select_n, output_enable_n, write_enable_n;
  logic        ras_n, cas_n, col_phase;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, mem_addr, rd;
  logic [3:0]  s_axi_wstrb, col_bits, col_c;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [14:0] scfg [3] = '{15'h34d0, 15'h6030, 15'h4f60};
  int          setup_c, cos_c, acc_c, och_c, cah_c, beats_c, rcd_c, casw_c, pre_c, act_c;
  int          mismatches, cmp_count;
  row_t        rows [9];
  bank67_pkg::mem_req_t req;
  bank67_memory_timing_config i_bank67_memory_timing_config (.*);
  bank67_mem_model i_bank67_mem_model (.*);
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic near(input string what, input int seen, input int exp);
    check(what, (seen >= exp && seen <= exp + 1) ? exp : seen, exp);
  endtask : near
  function automatic int d4(input logic [1:0] c);
    return (c == 2'h3) ? 4 : int'(c);
  endfunction : d4
  function automatic int dacc(input logic [2:0] c);
    int t [8] = '{1, 2, 3, 4, 6, 8, 10, 14};
    return t[c];
  endfunction : dacc
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [31:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  task automatic access(input logic bank7);
    int n;
    @(posedge aclk);
    clr <= 1'b1;
    req <= '{addr: 32'h0000_0100, write: 1'b0, last: 1'b1};
    req_bank7 <= bank7;
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      clr <= 1'b0;
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (acc_done !== 1'b1 && acc_error !== 1'b1 && n < 400);
    err = acc_error;
    check("access end", 32'(n < 400), 32'h0000_0001);
    repeat (2) @(posedge aclk);
  endtask : access
  ////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    #(50 * 20000);
    mismatches++;
    wrap_up();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {req_valid, req_bank7, clr, aresetn} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    req = '0;
    rows = '{'{0, b6, 0, rst, ok}, '{0, b7, 0, rst, ok}, '{1, b6, '1, 0, ok},
             '{0, b6, 0, 32'h0001_ffff, ok}, '{1, b7, 0, 0, ok}, '{0, b7, 0, 0, ok},
             '{0, 32'h01c8_0024, 0, 0, bad}, '{1, 32'h01c8_0024, '1, 0, bad},
             '{0, b6, 0, 32'h0001_ffff, ok}};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (rows[i]) begin
      if (rows[i].wr) axi_write(rows[i].a, rows[i].d);
      else axi_read(rows[i].a);
      if (!rows[i].wr) check("read data", rd, rows[i].exp);
      check("response", resp, rows[i].rsp);
    end
    $display("test register map done");
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_read(b7);
    check("reset value", rd, rst);
    access(1'b1);
    check("sdram refused", err, 1'b1);
    check("no strobes", act_c, 0);
    $display("test reset and sdram done");
    foreach (scfg[i]) begin
      axi_write(b6, {17'h0_0000, scfg[i]});
      access(1'b0);
      near("setup", setup_c, d4(scfg[i][14:13]));
      near("cs to oe", cos_c, d4(scfg[i][12:11]));
      check("strobe", acc_c, dacc(scfg[i][10:8]));
      near("cs hold", och_c, d4(scfg[i][7:6]));
      near("addr hold", cah_c, d4(scfg[i][5:4]));
      check("single beat", beats_c, 1);
      $display("test static %0d done", i);
    end
    for (int p = 1; p < 4; p++) begin
      axi_write(b7, 32'(p * 5));
      access(1'b1);
      check("beats", beats_c, 2 << p);
      $display("test burst %0d done", p);
    end
    for (int i = 0; i < 4; i++) begin
      axi_write(b6, (32'(i % 2 + 1) << 15) | 32'h0000_7fc0 |
                32'(i * 16 + (i % 2) * 8 + (1 - i % 2) * 4 + i));
      access(1'b0);
      check("ras to cas", rcd_c, i + 1);
      check("cas low", casw_c, i % 2 + 1);
      check("precharge", pre_c, 2 - i % 2);
      check("column width", {28'h000_0000, col_c}, 32'(i + 8));
      $display("test dram %0d done", i);
    end
    axi_write(b6, 32'h0000_0700);
    fork
      access(1'b0);
      axi_write(b6, 32'h0000_0000);
    join
    check("strobe kept", acc_c, 14);
    access(1'b0);
    check("strobe new", acc_c, 1);
    $display("test timing update done");
    wrap_up();
  end
endmodule : bank67_memory_timing_config_tb

bind bank67_memory_timing_config bank67_memory_timing_config_checker
  i_bank67_memory_timing_config_checker (.*);
